// >>> bench/sacf_conv_model.sv
// Converter model supplying its master clock.
// Assumes one system clock; clocks stand low while unused.
`timescale 1ns/1ps
module sacf_conv_model (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_en,
   output logic      o_mclk,
   output logic      o_bclk,
   output logic      o_frame
);
   logic [7:0] cnt_r;
   // Divide the system clock while clocks are supplied
   always_ff @(posedge i_clk_sys) begin
      cnt_r <= (!i_rst_n || !i_en) ? 8'h00 : cnt_r + 8'h01;
   end
   assign o_mclk = cnt_r[0];
   assign o_bclk = cnt_r[2];
   assign o_frame = cnt_r[7];
endmodule

// >>> bench/sacf_core_monitor.sv
// Port checker for the serial audio clock framer.
// Assumes it is bound into sacf_core.
`timescale 1ns/1ps
module sacf_core_monitor
   import sacf_pkg::*;
(
   input logic          i_clk_sys,
   input logic          i_rst_n,
   input logic          i_wr,
   input logic [AW-1:0] i_addr,
   input logic          o_out_en,
   input logic          o_frame_oe,
   input logic          o_bclk_oe,
   input logic          o_chan_oe,
   input logic          o_ref_oe,
   input logic          o_launch,
   input logic [4:0]    o_bit_idx,
   input logic          o_lead_pad,
   input logic          o_trail_pad,
   input logic          o_data_bit
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Launch strobe lasts exactly one cycle
   sequence s_launch;
      o_launch ##1 !o_launch;
   endsequence
   a_oe_gate: assert property ((o_frame_oe || o_bclk_oe) |-> o_out_en)
      else $error("pin enable while outputs off");
   a_ref_out: assert property (o_ref_oe == o_out_en)
      else $error("reference enable differs");
   a_chan_out: assert property (o_chan_oe == o_out_en)
      else $error("channel enable differs");
   a_ctrl_off: assert property (i_wr && i_addr == ADDR_CTRL |=> !o_out_en)
      else $error("outputs on after control write");
   a_start_off: assert property ($rose(i_rst_n) |-> !o_out_en)
      else $error("outputs on after reset");
   a_launch_one: assert property (o_launch |-> s_launch)
      else $error("launch longer than one cycle");
   a_bit_step: assert property (o_launch |=> o_bit_idx == 5'h0 ||
         o_bit_idx == $past(o_bit_idx) + 5'h1)
      else $error("bit index did not step");
   a_bit_class: assert property ($onehot0({o_lead_pad, o_trail_pad,
         o_data_bit}))
      else $error("bit in two classes");
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the serial audio clock framer.
// Assumes the package, monitor and converter model.
`timescale 1ns/1ps
module tb_top;
   import sacf_pkg::*;
   logic i_clk_sys, i_rst_n, i_wr, i_rd, i_frame, i_bclk, i_mclk, m_en;
   logic [7:0] i_addr, o_chan_idx;
   logic [31:0] i_wdata, o_rdata;
   logic [2:0] o_level;
   logic [4:0] o_bit_idx;
   logic o_frame, o_frame_oe, o_bclk, o_bclk_oe, o_mclk, o_mclk_oe, o_chan,
      o_chan_oe, o_ref, o_ref_oe, o_out_en, o_master, o_launch,
      o_lead_pad, o_trail_pad, o_data_bit;
   int miscompares, num_checks;
   sacf_core i_dut (.*);
   sacf_conv_model i_conv (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_en(m_en), .o_mclk(i_mclk), .o_bclk(i_bclk), .o_frame(i_frame));
   always #5 i_clk_sys = ~i_clk_sys;
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cyc(1);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      cyc(1);
      i_wr <= 1'b0;
   endtask
   task automatic rc(input string n, input logic [7:0] a,
         input logic [31:0] m, e);
      cyc(1);
      i_addr <= a;
      i_rd <= 1'b1;
      cyc(1);
      i_rd <= 1'b0;
      #1 chk(n, e, o_rdata & m);
   endtask
   task automatic cnt(input int n, lo, hi);
      int c;
      c = 0;
      repeat (n) begin
         cyc(1);
         if (o_launch === 1'b1) c++;
      end
      chk("launch count in range", 32'h1, 32'(c >= lo && c <= hi));
   endtask
   task automatic wfr;
      logic p;
      p = 1'b1;
      for (int k = 0; k < 2000; k++) begin
         cyc(1);
         if (o_frame === 1'b1 && p === 1'b0) return;
         p = o_frame;
      end
      miscompares++;
      tally_and_finish();
   endtask
   function automatic logic [31:0] sw(input logic [5:0] s, d, l, t);
      return {2'b0, t, 2'b0, l, 2'b0, d, 2'b0, s};
   endfunction
   task automatic t_regs;
      logic [31:0] rv[4];
      rv = '{32'd6749, 32'd216001, 32'd6750, 32'd216000};
      rc("ctrl", ADDR_CTRL, '1, 32'(CTRL_RST));
      rc("master", ADDR_STAT, 32'h1, 32'h1);
      chk("o_master", 32'h1, o_master);
      rc("hole", 8'h40, '1, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_RATE, rv[i]);
         rc("rej", ADDR_STAT, 32'h2, i < 2 ? 32'h2 : 32'h0);
         rc("rate", ADDR_RATE, '1, i < 2 ? 32'(RATE_RST) : rv[i]);
      end
   endtask
   task automatic t_slot;
      wr(ADDR_SLOT, sw(16, 24, 0, 8));
      rc("force", ADDR_STAT, 32'h40, 32'h40);
      rc("slot", ADDR_SLOT, 32'h3f, 32'd24);
      wr(ADDR_SLOT, sw(28, 20, 3, 6));
      rc("pad1", ADDR_SLOT, 32'h3f3f003f, sw(28, 0, 3, 5));
      wr(ADDR_SLOT, sw(22, 20, 3, 6));
      rc("pad2", ADDR_SLOT, 32'h3f3f003f, sw(22, 0, 2, 0));
      wr(ADDR_SLOT, sw(33, 20, 0, 0));
      rc("srej", ADDR_STAT, 32'h4, 32'h4);
      wr(ADDR_SLOT, sw(8, 8, 0, 0));
      rc("slot8", ADDR_SLOT, 32'h3f, 32'd8);
   endtask
   task automatic t_rates;
      wr(ADDR_CHAN, 32'd0);
      cyc(40);
      rc("brate", ADDR_BRATE, '1, 32'd1728000);
      wr(ADDR_CHAN, 32'd255);
      cyc(40);
      rc("bbad", ADDR_STAT, 32'h8, 32'h8);
      rc("bzero", ADDR_BRATE, '1, 32'h0);
      wr(ADDR_CHAN, 32'd0);
      wr(ADDR_RATE, 32'd50000);
      wr(ADDR_NMUL, 32'd200);
      cyc(70);
      rc("rrate", ADDR_RRATE, '1, 32'd10000000);
      wr(ADDR_NMUL, 32'd256);
      cyc(70);
      rc("rbad", ADDR_STAT, 32'h10, 32'h10);
      wr(ADDR_RATE, 32'd216000);
   endtask
   task automatic t_volt;
      wr(ADDR_VOLT, 32'h101);
      #1 chk("en", 32'h1, o_out_en);
      wr(ADDR_VOLT, 32'h103);
      #1 chk("hi", 32'h0, o_out_en);
      wr(ADDR_VOLT, 32'h105);
      #1 chk("lvl", 32'h3, o_level);
      wr(ADDR_VOLT, 32'h102);
      wr(ADDR_CTRL, 32'(CTRL_RST));
      #1 chk("ctl", 32'h0, o_out_en);
   endtask
   task automatic t_slave;
      wr(ADDR_MMUL, 32'd16);
      rc("mmul0", ADDR_MMUL, '1, 32'h0);
      wr(ADDR_CTRL, 32'h7);
      wr(ADDR_MMUL, 32'd16);
      rc("mmul", ADDR_MMUL, '1, 32'd16);
      rc("slave", ADDR_STAT, 32'h1, 32'h0);
      m_en <= 1'b1;
      cyc(70);
      cnt(400, 98, 102);
      m_en <= 1'b0;
   endtask
   task automatic t_frame;
      wr(ADDR_CTRL, 32'h8f);
      cyc(40);
      cnt(5788, 99, 101);
      wfr();
      chk("bit0", 32'h0, o_bit_idx);
      chk("ch0", 32'h0, o_chan_idx);
      wr(ADDR_CTRL, 32'h9f);
      wfr();
      chk("early", 32'h7, o_bit_idx);
      // Bit-wide frame pulse is low again after one bit
      wr(ADDR_CTRL, 32'hbf);
      wfr();
      cyc(70);
      chk("bitwide", 32'h0, o_frame);
      wr(ADDR_CTRL, 32'h2bf);
      #1 chk("finv", 32'h1, o_frame);
   endtask
   // Reset, then each scenario in turn
   initial begin
      {i_clk_sys, i_rst_n, i_wr, i_rd, m_en} = 5'h0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      cyc(20);
      i_rst_n <= 1'b1;
      t_regs();
      t_slot();
      t_rates();
      t_volt();
      t_slave();
      t_frame();
      tally_and_finish();
   end
endmodule
bind sacf_core sacf_core_monitor i_mon (.*);

// >>> core/sacf_core.sv
// Clock and frame generator for a serial audio port.
// Assumes synchronous pin inputs and a one-cycle register port.
`timescale 1ns/1ps
module sacf_core #(
   parameter int MAX_BCLK_HZ = 25_000_000,
   parameter int MAX_REF_HZ  = 50_000_000
) (
   input  logic                    i_clk_sys,
   input  logic                    i_rst_n,
   input  logic [sacf_pkg::AW-1:0] i_addr,
   input  logic [sacf_pkg::DW-1:0] i_wdata,
   input  logic                    i_wr,
   input  logic                    i_rd,
   output logic [sacf_pkg::DW-1:0] o_rdata,
   input  logic                    i_frame,
   output logic                    o_frame,
   output logic                    o_frame_oe,
   input  logic                    i_bclk,
   output logic                    o_bclk,
   output logic                    o_bclk_oe,
   input  logic                    i_mclk,
   output logic                    o_mclk,
   output logic                    o_mclk_oe,
   output logic                    o_chan,
   output logic                    o_chan_oe,
   output logic                    o_ref,
   output logic                    o_ref_oe,
   output logic [2:0]              o_level,
   output logic                    o_out_en,
   output logic                    o_master,
   output logic                    o_launch,
   output logic [4:0]              o_bit_idx,
   output logic [7:0]              o_chan_idx,
   output logic                    o_lead_pad,
   output logic                    o_trail_pad,
   output logic                    o_data_bit
);
   import sacf_pkg::*;

   if (MAX_BCLK_HZ < 1 || MAX_BCLK_HZ > SYS_HZ / 4) begin : g_chk_b
      $error("MAX_BCLK_HZ out of range");
   end
   if (MAX_REF_HZ < 1 || MAX_REF_HZ > SYS_HZ) begin : g_chk_r
      $error("MAX_REF_HZ out of range");
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_r;
   logic [17:0]       rate_r;
   logic [7:0]        chan_r;
   logic [5:0]        slot_r;
   logic [5:0]        dlen_r;
   logic [5:0]        lead_r;
   logic [5:0]        trail_r;
   logic [9:0]        nmul_r;
   logic [15:0]       mmul_r;
   logic [2:0]        lvl_r;
   logic              outen_r;
   logic              rrej_r;
   logic              srej_r;
   logic              rate_ok;
   logic              slot_ok;
   logic [5:0]        w_slot;
   logic [5:0]        w_dlen;
   logic [2:0]        w_lvl;

   assign w_slot  = i_wdata[SL_SLOT +: FW];
   assign w_dlen  = i_wdata[SL_DLEN +: FW];
   assign w_lvl   = i_wdata[VT_LVL +: 3];
   assign rate_ok = i_wdata >= RATE_MIN_HZ &&
                    i_wdata <= RATE_MAX_HZ;
   assign slot_ok = w_slot >= SLOT_MIN && w_slot <= SLOT_MAX &&
                    w_dlen >= 1 && w_dlen <= SLOT_MAX;

   // Register writes
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         ctrl_r  <= CTRL_RST;
         rate_r  <= RATE_RST;
         chan_r  <= CHAN_RST;
         slot_r  <= SLOT_RST;
         dlen_r  <= DLEN_RST;
         lead_r  <= LEAD_RST;
         trail_r <= TRAIL_RST;
         nmul_r  <= NMUL_RST;
         mmul_r  <= MMUL_RST;
      end else if (i_wr) begin
         case (i_addr)
            ADDR_CTRL: ctrl_r <= i_wdata[CTRL_W-1:0];
            ADDR_RATE: if (rate_ok) rate_r <= i_wdata[17:0];
            ADDR_CHAN: chan_r <= i_wdata[7:0];
            ADDR_SLOT: if (slot_ok) begin
               slot_r  <= w_slot;
               dlen_r  <= w_dlen;
               lead_r  <= i_wdata[SL_LEAD +: FW];
               trail_r <= i_wdata[SL_TRAIL +: FW];
            end
            ADDR_NMUL: if (i_wdata[9:0] != '0 && i_wdata[31:10] == '0) begin
               nmul_r <= i_wdata[9:0];
            end
            ADDR_MMUL: if (!ctrl_r[CT_MOUT] && i_wdata[15:0] != '0) begin
               mmul_r <= i_wdata[15:0];
            end
            default: ;
         endcase
      end
   end

   // Outcome of the last rate and slot writes
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rrej_r <= 1'b0;
         srej_r <= 1'b0;
      end else if (i_wr && i_addr == ADDR_RATE) begin
         rrej_r <= !rate_ok;
      end else if (i_wr && i_addr == ADDR_SLOT) begin
         srej_r <= !slot_ok;
      end
   end

   // Logic level and output drivers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         lvl_r   <= '0;
         outen_r <= 1'b0;
      end else if (i_wr && i_addr == ADDR_CTRL) begin
         outen_r <= 1'b0;
      end else if (i_wr && i_addr == ADDR_VOLT && w_lvl <= LVL_MAX) begin
         lvl_r <= w_lvl;
         if (outen_r && w_lvl > lvl_r) begin
            outen_r <= 1'b0;
         end else begin
            outen_r <= i_wdata[VT_EN];
         end
      end
   end

   // ----------------------------------------------------------------
   // Slot geometry and rate arithmetic
   // ----------------------------------------------------------------
   logic [5:0]  slot_eff;
   logic [5:0]  avail;
   logic [5:0]  lead_eff;
   logic [5:0]  trail_eff;
   logic [8:0]  ch_cnt;
   logic [14:0] total;
   logic [33:0] brate;
   logic [27:0] rrate;
   logic        mout;
   logic        bout;
   logic        fout;
   logic        master;

   assign slot_eff  = (slot_r < dlen_r) ? dlen_r : slot_r;
   assign avail     = slot_eff - dlen_r;
   assign lead_eff  = (lead_r < avail) ? lead_r : avail;
   assign trail_eff = avail - lead_eff;
   assign ch_cnt    = {1'b0, chan_r} + 9'h001;
   assign total     = 15'(ch_cnt) * 15'(slot_eff);
   assign brate     = 34'(rate_r) * 34'(total);
   assign rrate     = 28'(rate_r) * 28'(nmul_r);
   assign mout      = ctrl_r[CT_MOUT];
   assign bout      = ctrl_r[CT_BOUT];
   assign fout      = ctrl_r[CT_FOUT];
   assign master    = fout && bout && mout;

   // Reference divider: sys/(N*rate) as master, M/N as slave
   logic [31:0] a_q;
   logic        a_exact;
   logic [31:0] b_q;
   logic        b_exact;

   sacf_divchk #(.W(32)) u_div_ref (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_num     (mout ? 32'(SYS_HZ) : 32'(mmul_r)),
      .i_den     (mout ? 32'(rrate) : 32'(nmul_r)),
      .o_quot    (a_q),
      .o_exact   (a_exact)
   );

   // Bit divider from external master clock: M/(channels*bits)
   sacf_divchk #(.W(32)) u_div_bit (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_num     (32'(mmul_r)),
      .i_den     (32'(total)),
      .o_quot    (b_q),
      .o_exact   (b_exact)
   );

   logic bclk_bad;
   logic ref_ok;
   logic sbit_ok;
   logic clk_ok;
   logic running;

   assign bclk_bad = brate > 34'(MAX_BCLK_HZ);
   assign ref_ok   = a_exact && a_q >= DIV_MIN && a_q <= DIV_MAX &&
                     (!mout || rrate <= 28'(MAX_REF_HZ));
   assign sbit_ok  = b_exact && b_q >= 2 && b_q[31:16] == '0;
   assign clk_ok   = !bout || (mout ? !bclk_bad : sbit_ok);
   assign running  = ctrl_r[CT_RUN] && clk_ok;

   // ----------------------------------------------------------------
   // Master clock, reference clock and bit clock generation
   // ----------------------------------------------------------------
   logic [15:0] lfsr_r;
   logic        mclk_q;
   logic        mrise;
   logic        rtick;
   logic [9:0]  rper;
   logic [9:0]  rcnt_r;
   logic        ref_r;

   // Dither source for jitter
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         lfsr_r <= LFSR_SEED;
      end else begin
         lfsr_r <= {lfsr_r[14:0],
                    lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= i_mclk;
      end
   end

   assign mrise = i_mclk && !mclk_q;
   assign rtick = mout ? 1'b1 : mrise;
   assign rper  = 10'(a_q[8:0]) +
                  10'(ctrl_r[CT_JIT] && mout && lfsr_r[0]);

   // Integer divider for the reference clock
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !ref_ok) begin
         rcnt_r <= '0;
         ref_r  <= 1'b0;
      end else if (rtick) begin
         rcnt_r <= (rcnt_r >= rper - 10'h001) ? '0 : rcnt_r + 10'h001;
         ref_r  <= rcnt_r < (rper >> 1);
      end
   end

   logic [27:0] acc_r;
   logic [28:0] acc_sum;
   logic [15:0] bcnt_r;
   logic        bgen_r;

   assign acc_sum = 29'(acc_r) + 29'({brate[26:0], 1'b0}) +
                    29'(ctrl_r[CT_JIT] ? lfsr_r[3:1] : 3'h0);

   // Bit clock: phase accumulator as master, mclk divider as slave
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !running || !bout) begin
         acc_r  <= '0;
         bcnt_r <= '0;
         bgen_r <= 1'b0;
      end else if (mout) begin
         if (acc_sum >= 29'(SYS_HZ)) begin
            acc_r  <= 28'(acc_sum - 29'(SYS_HZ));
            bgen_r <= !bgen_r;
         end else begin
            acc_r <= acc_sum[27:0];
         end
      end else if (mrise) begin
         bcnt_r <= (bcnt_r >= b_q[15:0] - 16'h0001) ? '0 :
                   bcnt_r + 16'h0001;
         bgen_r <= bcnt_r < (b_q[15:0] >> 1);
      end
   end

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   logic        bnow;
   logic        bclk_q;
   logic        brise;
   logic        bfall;
   logic        fin;
   logic        fin_q;
   logic        sync_hit;
   logic        early;
   logic [4:0]  slot_last;
   logic [12:0] total_last;
   logic [4:0]  bit_r;
   logic [4:0]  bit_nxt;
   logic [7:0]  cidx_r;
   logic [7:0]  cidx_nxt;
   logic [12:0] pos_r;
   logic [12:0] pos_nxt;
   logic [12:0] pos_adj;
   logic        flvl;
   logic        clvl;
   logic        frame_r;
   logic        chan_r_lvl;

   assign bnow       = bout ? bgen_r : i_bclk;
   assign brise      = running && bnow && !bclk_q;
   assign bfall      = running && !bnow && bclk_q;
   assign fin        = i_frame ^ ctrl_r[CT_FINV];
   assign sync_hit   = !fout && brise && fin && !fin_q;
   assign early      = ctrl_r[CT_EARLY];
   assign slot_last  = 5'(slot_eff - 6'h01);
   assign total_last = 13'(total - 15'h0001);

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         bclk_q <= 1'b0;
         fin_q  <= 1'b0;
      end else begin
         bclk_q <= bnow;
         if (brise) begin
            fin_q <= fin;
         end
      end
   end

   // Next bit position; bits start on the bit clock falling edge
   always_comb begin
      bit_nxt  = bit_r;
      cidx_nxt = cidx_r;
      pos_nxt  = pos_r;
      if (sync_hit) begin
         bit_nxt  = early ? slot_last : '0;
         cidx_nxt = early ? chan_r : '0;
         pos_nxt  = early ? total_last : '0;
      end else if (bfall) begin
         if (bit_r == slot_last) begin
            bit_nxt  = '0;
            cidx_nxt = (cidx_r == chan_r) ? '0 : cidx_r + 8'h01;
         end else begin
            bit_nxt = bit_r + 5'h01;
         end
         pos_nxt = (pos_r == total_last) ? '0 : pos_r + 13'h0001;
      end
   end

   // Frame and channel levels from the bit position
   always_comb begin
      pos_adj = pos_nxt;
      if (early) begin
         pos_adj = (pos_nxt == total_last) ? '0 :
                   pos_nxt + 13'h0001;
      end
      flvl = ctrl_r[CT_FBW] ? (pos_adj == '0) :
             (15'(pos_adj) < (total >> 1));
      clvl = ctrl_r[CT_CBW] ? (bit_nxt == '0) :
             (6'(bit_nxt) < (slot_eff >> 1));
   end

   // Counters and pad flags
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !running) begin
         bit_r      <= '0;
         cidx_r     <= '0;
         pos_r      <= '0;
         o_lead_pad <= 1'b0;
         o_trail_pad <= 1'b0;
         o_data_bit <= 1'b0;
      end else begin
         bit_r       <= bit_nxt;
         cidx_r      <= cidx_nxt;
         pos_r       <= pos_nxt;
         o_lead_pad  <= 6'(bit_nxt) < lead_eff;
         o_trail_pad <= 6'(bit_nxt) >= slot_eff - trail_eff;
         o_data_bit  <= 6'(bit_nxt) >= lead_eff &&
                        6'(bit_nxt) < slot_eff - trail_eff;
      end
   end

   // Frame and channel transitions on the chosen bit clock edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !running) begin
         frame_r    <= 1'b0;
         chan_r_lvl <= 1'b0;
      end else begin
         if (ctrl_r[CT_FFALL] ? bfall : brise) begin
            frame_r <= flvl;
         end
         if (ctrl_r[CT_CFALL] ? bfall : brise) begin
            chan_r_lvl <= clvl;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign o_frame    = frame_r ^ ctrl_r[CT_FINV];
   assign o_chan     = chan_r_lvl ^ ctrl_r[CT_CINV];
   assign o_ref      = ref_r ^ ctrl_r[CT_RINV];
   assign o_bclk     = bgen_r;
   assign o_mclk     = ref_r;
   assign o_frame_oe = outen_r && fout;
   assign o_bclk_oe  = outen_r && bout;
   assign o_mclk_oe  = outen_r && mout;
   assign o_chan_oe  = outen_r;
   assign o_ref_oe   = outen_r;
   assign o_level    = lvl_r;
   assign o_out_en   = outen_r;
   assign o_master   = master;
   assign o_launch   = bfall;
   assign o_bit_idx  = bit_r;
   assign o_chan_idx = cidx_r;

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   logic [DW-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      case (i_addr)
         ADDR_CTRL: rd_mux = DW'(ctrl_r);
         ADDR_RATE: rd_mux = DW'(rate_r);
         ADDR_CHAN: rd_mux = DW'(chan_r);
         ADDR_SLOT: begin
            rd_mux[SL_SLOT +: FW]  = slot_eff;
            rd_mux[SL_DLEN +: FW]  = dlen_r;
            rd_mux[SL_LEAD +: FW]  = lead_eff;
            rd_mux[SL_TRAIL +: FW] = trail_eff;
         end
         ADDR_NMUL: rd_mux = DW'(nmul_r);
         ADDR_MMUL: rd_mux = mout ? '0 : DW'(mmul_r);
         ADDR_VOLT: begin
            rd_mux[VT_LVL +: 3] = lvl_r;
            rd_mux[VT_EN]       = outen_r;
         end
         ADDR_STAT: begin
            rd_mux[ST_MASTER]  = master;
            rd_mux[ST_RREJ]    = rrej_r;
            rd_mux[ST_SREJ]    = srej_r;
            rd_mux[ST_BBAD]    = bclk_bad;
            rd_mux[ST_RBAD]    = !ref_ok;
            rd_mux[ST_OUTEN]   = outen_r;
            rd_mux[ST_FORCE]   = slot_r < dlen_r;
            rd_mux[ST_RUNNING] = running;
         end
         ADDR_BRATE: rd_mux = bclk_bad ? '0 : brate[31:0];
         ADDR_RRATE: rd_mux = ref_ok ? DW'(rrate) : '0;
         default: rd_mux = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= i_rd ? rd_mux : '0;
      end
   end
endmodule

// >>> core/sacf_divchk.sv
// Serial restoring divider: quotient and an exactness flag.
// Assumes operands stay still for one pass of W+1 cycles.
`timescale 1ns/1ps
module sacf_divchk #(
   parameter int W = 32
) (
   input  logic         i_clk_sys,
   input  logic         i_rst_n,
   input  logic [W-1:0] i_num,
   input  logic [W-1:0] i_den,
   output logic [W-1:0] o_quot,
   output logic         o_exact
);
   if (W < 2) begin : g_chk
      $error("sacf_divchk width too small");
   end

   logic [W:0]           rem_r;
   logic [W-1:0]         sh_r;
   logic [$clog2(W+1):0] cnt_r;
   logic [W:0]           trial;
   logic                 ge;
   logic [W:0]           rem_nxt;

   // One shift-subtract step
   always_comb begin
      trial   = {rem_r[W-1:0], sh_r[W-1]};
      ge      = trial >= {1'b0, i_den};
      rem_nxt = ge ? trial - {1'b0, i_den} : trial;
   end

   // Iterate, then publish and restart
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rem_r   <= '0;
         sh_r    <= '0;
         cnt_r   <= '0;
         o_quot  <= '0;
         o_exact <= 1'b0;
      end else if (cnt_r == '0) begin
         rem_r <= '0;
         sh_r  <= i_num;
         cnt_r <= ($clog2(W+1)+1)'(W);
      end else begin
         rem_r <= rem_nxt;
         sh_r  <= {sh_r[W-2:0], ge};
         cnt_r <= cnt_r - 1'b1;
         if (cnt_r == 1) begin
            o_quot  <= {sh_r[W-2:0], ge};
            o_exact <= (rem_nxt == '0) && (i_den != '0);
         end
      end
   end
endmodule

// >>> inc/sacf_pkg.sv
// Constants shared by the serial audio clock framer and its bench.
// Assumes a 100 MHz system clock and a byte-addressed register port.
package sacf_pkg;
   // ----------------------------------------------------------------
   // Register port and map
   // ----------------------------------------------------------------
   localparam int         AW         = 8;
   localparam int         DW         = 32;
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_RATE  = 8'h04;
   localparam logic [7:0] ADDR_CHAN  = 8'h08;
   localparam logic [7:0] ADDR_SLOT  = 8'h0c;
   localparam logic [7:0] ADDR_NMUL  = 8'h10;
   localparam logic [7:0] ADDR_MMUL  = 8'h14;
   localparam logic [7:0] ADDR_VOLT  = 8'h18;
   localparam logic [7:0] ADDR_STAT  = 8'h1c;
   localparam logic [7:0] ADDR_BRATE = 8'h20;
   localparam logic [7:0] ADDR_RRATE = 8'h24;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_W  = 13;
   localparam int CT_RUN  = 0;
   localparam int CT_FOUT = 1;
   localparam int CT_BOUT = 2;
   localparam int CT_MOUT = 3;
   localparam int CT_EARLY = 4;
   localparam int CT_FBW  = 5;
   localparam int CT_CBW  = 6;
   localparam int CT_FFALL = 7;
   localparam int CT_CFALL = 8;
   localparam int CT_FINV = 9;
   localparam int CT_CINV = 10;
   localparam int CT_RINV = 11;
   localparam int CT_JIT  = 12;
   localparam int FW      = 6;
   localparam int SL_SLOT = 0;
   localparam int SL_DLEN = 8;
   localparam int SL_LEAD = 16;
   localparam int SL_TRAIL = 24;
   localparam int VT_LVL  = 0;
   localparam int VT_EN   = 8;
   localparam int ST_MASTER = 0;
   localparam int ST_RREJ  = 1;
   localparam int ST_SREJ  = 2;
   localparam int ST_BBAD  = 3;
   localparam int ST_RBAD  = 4;
   localparam int ST_OUTEN = 5;
   localparam int ST_FORCE = 6;
   localparam int ST_RUNNING = 7;
   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [12:0] CTRL_RST  = 13'h000e;
   localparam logic [17:0] RATE_RST  = 18'h0bb80;
   localparam logic [7:0]  CHAN_RST  = 8'h01;
   localparam logic [5:0]  SLOT_RST  = 6'h20;
   localparam logic [5:0]  DLEN_RST  = 6'h18;
   localparam logic [5:0]  LEAD_RST  = 6'h00;
   localparam logic [5:0]  TRAIL_RST = 6'h08;
   localparam logic [9:0]  NMUL_RST  = 10'h100;
   localparam logic [15:0] MMUL_RST  = 16'h0100;
   localparam logic [2:0]  LVL_MAX   = 3'h4;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYS_HZ      = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int RATE_MIN_HZ = 6750;
   localparam int RATE_MAX_HZ = 216000;
   localparam int SLOT_MIN    = 8;
   localparam int SLOT_MAX    = 32;
   localparam int DIV_MIN     = 1;
   localparam int DIV_MAX     = 256;
endpackage
